//--- rtl/irc_config.sv
// interrupt routing configuration: node identifiers and lowest-priority redirection control
// Overview of operation
// [RQ1] three 3-bit node ids at 12:10, 7:5, 2:0, reset zero
// [RQ2] override bit 18: 0 locks mode bit; 1 lets software write, ignores messages
// [RQ3] software returns override to 0 after a one-time change
// [RQ4] bit 17 mode, 0 flat 1 cluster, firmware or message updated
// [RQ5] bit 16 set: message mode sampled only when logical id is non-zero
// [RQ6] bits 10:8 choose hash vector bits; codes above 011 reserved
// [RQ7] bits 6:4 choose fixed, round-robin or vector hash redirection
// [RQ8] writing 1 to bit 1 forces x2 mode; writing 0 does nothing
// [RQ9] bit 0 extended apic enable, reset 1, software or message updated
// [RQ10] reset restores defaults; written fields apply from the next cycle
`timescale 1ns/1ps
module irc_config
    import irc_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire irc_cfg_req_s cfg_req_i,
    input wire irc_prio_msg_s prio_msg_i,
    input wire logic [7:0] vector_i,
    output logic [31:0] cfg_rdata_o,
    output logic cfg_rvalid_o,
    output logic [2:0] legacy_socket_node_o,
    output logic [2:0] lock_master_node_o,
    output logic [2:0] local_socket_node_o,
    output logic flat_cluster_select_o,
    output logic extended_apic_enable_o,
    output logic force_extended2_apic_o,
    output irc_redir_e redirection_scheme_o,
    output logic [3:0] hash_index_o,
    output logic hash_select_reserved_o
);
    // node identifiers
    logic [2:0] legacy_r;
    logic [2:0] lock_r;
    logic [2:0] local_r;
    // interrupt configuration fields
    logic ovr_en_r;
    logic flat_clus_r;
    logic clus_chk_r;
    logic force_x2_r;
    logic xapic_r;
    logic [2:0] hash_sel_r;
    logic hash_rsvd_r;
    logic [2:0] redir_r;
    // read path and hash pick
    logic [31:0] rdata_nxt;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [3:0] hash_r;

    // address decode shared by the write strobes and the read mux
    wire hit_node = (cfg_req_i.addr == IRC_OFF_NODE_ID);
    wire hit_int = (cfg_req_i.addr == IRC_OFF_INT_CFG);
    wire wr_node = cfg_req_i.wr && hit_node;
    wire wr_int = cfg_req_i.wr && hit_int;
    wire [31:0] wd = cfg_req_i.wdata;
    // mode message sample allowed only when not overridden and id check passes; xapic takes every valid message unless wr_int is set in the same cycle
    wire id_ok = !clus_chk_r || (prio_msg_i.logical_id != 32'h0000_0000); // [RQ5]
    wire msg_take = prio_msg_i.valid && !ovr_en_r && id_ok; // [RQ2] [RQ5]
    wire xapic_msg = prio_msg_i.valid; // [RQ9]

    // mode write counts only with the override already set
    wire mode_sw_wr = wr_int && ovr_en_r; // [RQ2]
    // reserved hash codes are flagged at write time so the output is a flop
    wire hash_rsvd_nxt = wd[IRC_HASH_LSB +: 3] > IRC_HASH_MAX; // [RQ6]

    wire [31:0] node_view = {19'h0, legacy_r, 2'h0, lock_r, 2'h0, local_r};
    wire [31:0] int_view = {13'h0, ovr_en_r, flat_clus_r, clus_chk_r, 5'h0, hash_sel_r,
                            1'b0, redir_r, 2'h0, force_x2_r, xapic_r};
    assign rdata_nxt = hit_node ? node_view :
                       hit_int ? int_view : 32'h0000_0000;

    // hash vector pick; cluster takes 4 bits, flat 2 bits zero-extended
    logic [3:0] hash_nxt;
    always_comb begin
        hash_nxt = 4'h0;
        unique case (hash_sel_r) // [RQ6]
            3'h0: hash_nxt = flat_clus_r ? vector_i[7:4] : {2'h0, vector_i[5:4]};
            3'h1: hash_nxt = flat_clus_r ? vector_i[6:3] : {2'h0, vector_i[4:3]};
            3'h2: hash_nxt = flat_clus_r ? vector_i[4:1] : {2'h0, vector_i[2:1]};
            3'h3: hash_nxt = flat_clus_r ? vector_i[3:0] : {2'h0, vector_i[1:0]};
            default: hash_nxt = 4'h0;
        endcase
    end

    // node ids are plain software registers with no hardware update
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin // [RQ10]
            legacy_r <= IRC_NODE_ID_RST[IRC_LEGACY_LSB +: IRC_NODE_W]; // [RQ1]
        end else if (wr_node) begin
            legacy_r <= wd[IRC_LEGACY_LSB +: IRC_NODE_W]; // [RQ1]
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            lock_r <= IRC_NODE_ID_RST[IRC_LOCK_LSB +: IRC_NODE_W];
        end else if (wr_node) begin
            lock_r <= wd[IRC_LOCK_LSB +: IRC_NODE_W]; // [RQ1]
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            local_r <= IRC_NODE_ID_RST[IRC_LOCAL_LSB +: IRC_NODE_W];
        end else if (wr_node) begin
            local_r <= wd[IRC_LOCAL_LSB +: IRC_NODE_W]; // [RQ1]
        end
    end

    // override enable is software only; it gates the mode bit below
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            ovr_en_r <= IRC_INT_CFG_RST[IRC_OVR_EN_BIT];
        end else if (wr_int) begin // [RQ10]
            ovr_en_r <= wd[IRC_OVR_EN_BIT]; // [RQ2]
        end
    end

    // enables the non-zero id test on message sampling
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            clus_chk_r <= IRC_INT_CFG_RST[IRC_CLUS_CHK_BIT];
        end else if (wr_int) begin
            clus_chk_r <= wd[IRC_CLUS_CHK_BIT]; // [RQ5]
        end
    end

    // hash code and its reserved flag move together
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            hash_sel_r <= IRC_INT_CFG_RST[IRC_HASH_LSB +: 3];
            hash_rsvd_r <= IRC_INT_CFG_RST[IRC_HASH_LSB +: 3] > IRC_HASH_MAX;
        end else if (wr_int) begin
            hash_sel_r <= wd[IRC_HASH_LSB +: 3]; // [RQ6]
            hash_rsvd_r <= hash_rsvd_nxt; // [RQ6]
        end
    end

    // redirection scheme steers lowest-priority delivery
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            redir_r <= IRC_INT_CFG_RST[IRC_REDIR_LSB +: 3];
        end else if (wr_int) begin
            redir_r <= wd[IRC_REDIR_LSB +: 3]; // [RQ7]
        end
    end

    // mode bit: software write needs override set, which also blocks messages
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            flat_clus_r <= IRC_INT_CFG_RST[IRC_FLAT_CLUS_BIT];
        end else if (mode_sw_wr) begin
            flat_clus_r <= wd[IRC_FLAT_CLUS_BIT]; // [RQ2] [RQ4]
        end else if (msg_take) begin
            flat_clus_r <= prio_msg_i.flat_cluster; // [RQ4]
        end
    end

    // software write wins over a message in the same cycle
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            xapic_r <= IRC_INT_CFG_RST[IRC_XAPIC_BIT];
        end else if (wr_int) begin
            xapic_r <= wd[IRC_XAPIC_BIT]; // [RQ9]
        end else if (xapic_msg) begin
            xapic_r <= prio_msg_i.xapic; // [RQ9]
        end
    end

    // force is sticky until reset; a zero write leaves it alone
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            force_x2_r <= IRC_INT_CFG_RST[IRC_FORCE_X2_BIT];
        end else if (wr_int && wd[IRC_FORCE_X2_BIT]) begin
            force_x2_r <= 1'b1; // [RQ8]
        end
    end

    // read answer: one-cycle pulse
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            rvalid_r <= 1'b0;
        end else begin
            rvalid_r <= cfg_req_i.rd;
        end
    end

    // read data is zero when idle and for unmapped offsets
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            rdata_r <= 32'h0000_0000;
        end else begin
            rdata_r <= cfg_req_i.rd ? rdata_nxt : 32'h0000_0000;
        end
    end

    // hash index follows the vector one cycle late
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            hash_r <= 4'h0;
        end else begin
            hash_r <= hash_nxt; // [RQ6]
        end
    end

    // every output below is a register
    assign cfg_rdata_o = rdata_r;
    assign cfg_rvalid_o = rvalid_r;
    assign legacy_socket_node_o = legacy_r;
    assign lock_master_node_o = lock_r;
    assign local_socket_node_o = local_r;
    assign flat_cluster_select_o = flat_clus_r;
    assign extended_apic_enable_o = xapic_r;
    assign force_extended2_apic_o = force_x2_r;
    assign redirection_scheme_o = irc_redir_e'(redir_r); // [RQ7]
    assign hash_index_o = hash_r;
    assign hash_select_reserved_o = hash_rsvd_r; // [RQ6]
endmodule // irc_config

//--- inc/irc_pkg.sv
// package: register map, field layout and types for the interrupt routing configuration
package irc_pkg;
    localparam logic [7:0] IRC_OFF_NODE_ID = 8'h40;
    localparam logic [7:0] IRC_OFF_INT_CFG = 8'h48;
    localparam int IRC_NODE_W = 3;
    localparam int IRC_LEGACY_LSB = 10;
    localparam int IRC_LOCK_LSB = 5;
    localparam int IRC_LOCAL_LSB = 0;
    localparam int IRC_OVR_EN_BIT = 18;
    localparam int IRC_FLAT_CLUS_BIT = 17;
    localparam int IRC_CLUS_CHK_BIT = 16;
    localparam int IRC_HASH_LSB = 8;
    localparam int IRC_REDIR_LSB = 4;
    localparam int IRC_FORCE_X2_BIT = 1;
    localparam int IRC_XAPIC_BIT = 0;
    localparam logic [31:0] IRC_NODE_ID_RST = 32'h0000_0000;
    localparam logic [31:0] IRC_INT_CFG_RST = 32'h0000_0001;
    localparam logic [2:0] IRC_HASH_MAX = 3'h3;

    typedef enum logic [2:0] {
        IRC_REDIR_FIXED = 3'h0,
        IRC_REDIR_RROBIN = 3'h1,
        IRC_REDIR_HASH = 3'h2
    } irc_redir_e;

    // configuration bus access
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } irc_cfg_req_s;

    // priority update message from the interrupt fabric
    typedef struct packed {
        logic valid;
        logic flat_cluster;
        logic xapic;
        logic [31:0] logical_id;
    } irc_prio_msg_s;
endpackage

//--- bench/irc_config_checker.sv
// checker: port assertions for the interrupt routing configuration
`timescale 1ns/1ps
module irc_config_checker
    import irc_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire irc_cfg_req_s cfg_req_i,
    input wire irc_prio_msg_s prio_msg_i,
    input wire logic cfg_rvalid_o,
    input wire logic flat_cluster_select_o,
    input wire logic extended_apic_enable_o,
    input wire logic force_extended2_apic_o,
    input wire irc_redir_e redirection_scheme_o,
    input wire logic [3:0] hash_index_o,
    input wire logic hash_select_reserved_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);
    wire w48 = cfg_req_i.wr && cfg_req_i.addr == IRC_OFF_INT_CFG;
    chk_read_answer: assert property (cfg_req_i.rd |=> cfg_rvalid_o)
        else $error("read unanswered");
    chk_mode_hold: assert property (!prio_msg_i.valid && !w48 |=> $stable(flat_cluster_select_o))
        else $error("mode moved");
    chk_redir_write: assert property (w48 |=> redirection_scheme_o == $past(cfg_req_i.wdata[6:4]))
        else $error("redir wrong");
    chk_force_sticky: assert property (force_extended2_apic_o |=> force_extended2_apic_o)
        else $error("force cleared");
    chk_force_set: assert property (w48 && cfg_req_i.wdata[1] |=> force_extended2_apic_o)
        else $error("force not set");
    chk_hash_rsvd: assert property (w48 |=> hash_select_reserved_o == ($past(cfg_req_i.wdata[10:8]) > 3))
        else $error("reserved flag wrong");
    chk_hash_zero: assert property (hash_select_reserved_o |=> hash_index_o == 4'h0)
        else $error("reserved hash code gave nonzero index");
    chk_xapic_write: assert property (w48 |=> extended_apic_enable_o == $past(cfg_req_i.wdata[0]))
        else $error("xapic wrong");
    chk_reset_dflt: assert property ($rose(rst_b_i) |-> extended_apic_enable_o && !force_extended2_apic_o)
        else $error("reset value wrong");
    cover property (cfg_req_i.rd);
    cover property (prio_msg_i.valid);
    cover property (force_extended2_apic_o);
    cover property (hash_select_reserved_o);
endmodule // irc_config_checker
bind irc_config irc_config_checker chk_u (.*);

//--- bench/interrupt_routing_config_tb.sv
// testbench: register and message scenarios for the interrupt routing configuration
`timescale 1ns/1ps
module interrupt_routing_config_tb;
    import irc_pkg::*;
    localparam logic [7:0] IC = IRC_OFF_INT_CFG;
    logic clock_i = 1'b0;
    logic rst_b_i = 1'b0;
    irc_cfg_req_s cfg_req_i = '0;
    irc_prio_msg_s prio_msg_i = '0;
    logic [7:0] vector_i = 8'h00;
    logic [31:0] cfg_rdata_o;
    logic cfg_rvalid_o, flat_cluster_select_o, extended_apic_enable_o, force_extended2_apic_o;
    logic hash_select_reserved_o;
    logic [2:0] legacy_socket_node_o, lock_master_node_o, local_socket_node_o;
    logic [3:0] hash_index_o;
    wire [8:0] nodes = {legacy_socket_node_o, lock_master_node_o, local_socket_node_o};
    irc_redir_e redirection_scheme_o;
    int errors = 0;
    int compares = 0;
    irc_config dut_u (.*);
    initial forever #25 clock_i = ~clock_i;
    task automatic chk(string n, logic [31:0] e, logic [31:0] s);
        compares++;
        if (s !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        cfg_req_i <= '{1'b1, 1'b0, a, d};
        @(posedge clock_i);
        cfg_req_i <= '0;
        @(posedge clock_i);
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] e);
        cfg_req_i <= '{1'b0, 1'b1, a, 32'h0};
        @(posedge clock_i);
        cfg_req_i <= '0;
        #1 chk("rvalid", 32'h1, {31'h0, cfg_rvalid_o});
        chk("rdata", e, cfg_rdata_o);
        @(posedge clock_i);
    endtask
    task automatic msg(logic f, logic [31:0] id);
        prio_msg_i <= '{1'b1, f, 1'b1, id};
        @(posedge clock_i);
        prio_msg_i <= '0;
        @(posedge clock_i);
    endtask
    task automatic results();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clock_i);
        rst_b_i <= 1'b1;
        rd(IRC_OFF_NODE_ID, IRC_NODE_ID_RST);
        rd(IC, IRC_INT_CFG_RST);
        wr(IRC_OFF_NODE_ID, 32'hFFFF_FFFF);
        rd(IRC_OFF_NODE_ID, 32'h0000_1CE7);
        wr(IRC_OFF_NODE_ID, 32'h0000_1446);
        chk("nodes", 32'h156, {23'h0, nodes});
        wr(IC, 32'h0002_0000);
        rd(IC, 32'h0000_0000);
        chk("xapic", 32'h0, {31'h0, extended_apic_enable_o});
        msg(1'b1, 32'h0);
        chk("mode", 32'h1, {31'h0, flat_cluster_select_o});
        chk("xapic", 32'h1, {31'h0, extended_apic_enable_o});
        wr(IC, 32'h0001_0001);
        msg(1'b0, 32'h0);
        chk("mode", 32'h1, {31'h0, flat_cluster_select_o});
        msg(1'b0, 32'h1);
        chk("mode", 32'h0, {31'h0, flat_cluster_select_o});
        wr(IC, 32'h0004_0001);
        wr(IC, 32'h0006_0101);
        msg(1'b0, 32'h1);
        rd(IC, 32'h0006_0101);
        vector_i <= 8'h48;
        repeat (2) @(posedge clock_i);
        chk("hash", 32'h9, {28'h0, hash_index_o});
        for (int i = 0; i < 3; i++) begin
            wr(IC, 32'(i) << IRC_REDIR_LSB);
            chk("redir", i, 32'(redirection_scheme_o));
        end
        wr(IC, 32'h0000_0500);
        @(posedge clock_i);
        chk("hash_rsvd", 32'h1, {31'h0, hash_select_reserved_o});
        chk("hash", 32'h0, {28'h0, hash_index_o});
        chk("xapic", 32'h0, {31'h0, extended_apic_enable_o});
        msg(1'b0, 32'h1);
        chk("mode", 32'h0, {31'h0, flat_cluster_select_o});
        vector_i <= 8'hB6;
        wr(IC, 32'h0000_0300);
        @(posedge clock_i);
        chk("hash", 32'h2, {28'h0, hash_index_o});
        chk("hash_rsvd", 32'h0, {31'h0, hash_select_reserved_o});
        wr(IC, 32'h0000_0002);
        wr(IC, 32'h0000_0000);
        chk("force", 32'h1, {31'h0, force_extended2_apic_o});
        rd(8'h44, 32'h0);
        rst_b_i <= 1'b0;
        @(posedge clock_i);
        rst_b_i <= 1'b1;
        rd(IC, IRC_INT_CFG_RST);
        chk("nodes", 32'h0, {23'h0, nodes});
        results();
    end
    initial begin
        repeat (2000) @(posedge clock_i);
        errors++;
        results();
    end
endmodule // interrupt_routing_config_tb
